/* File: hdl/uart_addr_wake_break.sv */
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/100ps
module uart_addr_wake_break import uart_wake_pkg::*; (
	input  wire logic        ref_clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        ce_in,
	input  wire logic        sleep_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        rx_line_in,
	output logic             tx_line_out,
	output logic             receive_flag_out,
	output logic             transmit_buffer_empty_flag_out,
	output logic             wake_async_out
);
	// ==========================================================
	// bit timing decode
	function automatic logic [5:0] bit_last(input logic hs, input logic wide);
		bit_last = (hs && wide) ? BIT_LAST_FAST : (hs || wide) ? BIT_LAST_MID : BIT_LAST_SLOW;
	endfunction

	function automatic logic [5:0] half_last(input logic hs, input logic wide);
		half_last = (hs && wide) ? HALF_LAST_FAST : (hs || wide) ? HALF_LAST_MID : HALF_LAST_SLOW;
	endfunction

	// control registers
	logic serial_port_enable, rx9, single_receive_enable, continuous_receive_enable, address_detect_enable, tx9, transmit_enable, high_speed_baud_select, tx9d, wide_baud_divisor_select, wake_on_edge_enable, auto_rate_enable, woke;
	logic next_serial_port_enable, next_rx9, next_single_receive_enable, next_continuous_receive_enable, next_address_detect_enable, next_tx9, next_transmit_enable;
	logic next_high_speed_baud_select, next_tx9d, next_wide_baud_divisor_select, next_wue, next_auto_rate_enable, next_woke;
	logic [7:0]  div_hi, div_lo, next_div_hi, next_div_lo;
	logic [31:0] next_prdata;
	logic        next_pslverr;
	// receiver
	rx_state_t   rx_state, next_rx_state;
	logic [5:0]  rx_cnt, next_rx_cnt;
	logic [3:0]  rx_bits, next_rx_bits;
	logic [8:0]  rx_shift, next_rx_shift;
	logic [7:0]  rx_buf, next_rx_buf;
	logic        received_ninth_bit, framing_error, overrun_error, rx_flag;
	logic        next_received_ninth_bit, next_framing_error, next_overrun_error, next_rx_flag;
	logic        rx_meta, rx_sync, rx_prev;
	// transmitter
	tx_state_t   tx_state, next_tx_state;
	logic [5:0]  tx_cnt, next_tx_cnt;
	logic [3:0]  tx_bits, next_tx_bits;
	logic [8:0]  tx_shift, next_tx_shift;
	logic [7:0]  tx_hold, next_tx_hold;
	logic        tx_full, break_send_request, tx_brk, tx_line;
	logic        next_tx_full, next_break_send_request, next_tx_brk, next_tx_line;

	logic        wr_acc, rd_acc, buf_read, set_flag, word_done, word_bit9;
	logic        rx_fall, rx_rise, run, tick, receiver_idle_status, shifter_empty_status;
	logic [7:0]  word_data, rd_val;
	logic [5:0]  rx_bl, tx_bl;

	// ==========================================================
	// baud tick
	baud_if bif ();
	assign bif.divisor = {div_hi, div_lo};
	assign bif.wide    = wide_baud_divisor_select;
	assign bif.run     = serial_port_enable & ~sleep_in;
	baud_gen u_baud (
		.ref_clk_in (ref_clk_in),
		.sys_rst_in (sys_rst_in),
		.ce_in      (ce_in),
		.bif        (bif)
	);

	assign run   = ~sleep_in;
	assign tick  = bif.tick;
	assign rx_bl = bit_last(high_speed_baud_select, wide_baud_divisor_select);
	assign tx_bl = rx_bl;

	// ==========================================================
	// APB: zero wait states; a low clock enable stretches the access
	assign pready_out = penable_in & ce_in;
	assign wr_acc     = psel_in & penable_in & pwrite_in;
	assign rd_acc     = psel_in & penable_in & ~pwrite_in;
	assign buf_read   = rd_acc && paddr_in == OFF_RX_BUF;
	assign receiver_idle_status      = rx_state == R_IDLE;
	assign shifter_empty_status       = tx_state == T_IDLE;
	assign rx_fall    = rx_prev & ~rx_sync;
	assign rx_rise    = ~rx_prev & rx_sync;
	assign word_data  = rx9 ? rx_shift[7:0] : rx_shift[8:1];
	assign word_bit9  = rx9 & rx_shift[8];
	// raw pin on purpose: raised with no clock edge at all while asleep
	assign wake_async_out = wake_on_edge_enable & ~woke & ~rx_line_in & sleep_in;
	assign receive_flag_out = rx_flag;
	assign transmit_buffer_empty_flag_out = transmit_enable & ~tx_full;
	assign tx_line_out = tx_line;

	always_comb begin
		rd_val = 8'h00;
		unique case (paddr_in)
			OFF_RX_STAT: rd_val = {serial_port_enable, rx9, single_receive_enable, continuous_receive_enable, address_detect_enable, framing_error, overrun_error, received_ninth_bit};
			OFF_RX_BUF:  rd_val = rx_buf;
			OFF_TX_STAT: rd_val = {1'b0, tx9, transmit_enable, 1'b0, break_send_request, high_speed_baud_select, shifter_empty_status, tx9d};
			OFF_BAUD:    rd_val = {1'b0, receiver_idle_status, 2'b00, wide_baud_divisor_select, 1'b0, wake_on_edge_enable, auto_rate_enable};
			OFF_DIV_HI:  rd_val = div_hi;
			OFF_DIV_LO:  rd_val = div_lo;
			default:     rd_val = 8'h00;
		endcase
	end

	// ==========================================================
	// line input synchroniser
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
			rx_prev <= 1'b1;
		end else if (ce_in) begin
			rx_meta <= rx_line_in;
			rx_sync <= rx_meta;
			rx_prev <= rx_sync;
		end
	end

	// ==========================================================
	// registers and receiver
	always_comb begin
		{next_serial_port_enable, next_rx9, next_single_receive_enable, next_continuous_receive_enable, next_address_detect_enable} = {serial_port_enable, rx9, single_receive_enable, continuous_receive_enable, address_detect_enable};
		{next_tx9, next_transmit_enable, next_high_speed_baud_select, next_tx9d} = {tx9, transmit_enable, high_speed_baud_select, tx9d};
		{next_wide_baud_divisor_select, next_wue, next_auto_rate_enable, next_woke} = {wide_baud_divisor_select, wake_on_edge_enable, auto_rate_enable, woke};
		next_div_hi   = div_hi;
		next_div_lo   = div_lo;
		next_rx_state = rx_state;
		next_rx_cnt   = rx_cnt;
		next_rx_bits  = rx_bits;
		next_rx_shift = rx_shift;
		next_rx_buf   = rx_buf;
		{next_received_ninth_bit, next_framing_error, next_overrun_error} = {received_ninth_bit, framing_error, overrun_error};
		set_flag      = 1'b0;
		word_done     = 1'b0;
		next_prdata   = prdata_out;
		next_pslverr  = pslverr_out;
		if (psel_in && !penable_in) begin
			next_prdata  = {24'h000000, rd_val};
			next_pslverr = paddr_in > OFF_TX_BUF || paddr_in[1:0] != 2'b00;
		end
		if (wr_acc) begin
			unique case (paddr_in)
				OFF_RX_STAT: begin
					next_serial_port_enable  = pwdata_in[B_SERIAL_PORT_ENABLE];
					next_rx9   = pwdata_in[B_RX9];
					next_single_receive_enable  = pwdata_in[B_SINGLE_RECEIVE_ENABLE];
					next_continuous_receive_enable  = pwdata_in[B_CONTINUOUS_RECEIVE_ENABLE];
					next_address_detect_enable = pwdata_in[B_ADDRESS_DETECT_ENABLE];
				end
				OFF_TX_STAT: begin
					next_tx9  = pwdata_in[B_TX9];
					next_transmit_enable = pwdata_in[B_TRANSMIT_ENABLE];
					next_high_speed_baud_select = pwdata_in[B_HIGH_SPEED_BAUD_SELECT];
					next_tx9d = pwdata_in[B_TX9D];
				end
				OFF_BAUD: begin
					next_wide_baud_divisor_select = pwdata_in[B_WIDE_BAUD_DIVISOR_SELECT];
					next_wue   = pwdata_in[B_WUE];
					next_auto_rate_enable = pwdata_in[B_AUTO_RATE_ENABLE];
					next_woke  = 1'b0;
				end
				OFF_DIV_HI: next_div_hi = pwdata_in[7:0];
				OFF_DIV_LO: next_div_lo = pwdata_in[7:0];
				default: ;
			endcase
		end
		if (wake_on_edge_enable) begin
			// wake watch runs on the core clock even in sleep
			next_rx_state = R_IDLE;
			if (!woke && rx_fall) begin
				next_woke = 1'b1;
				set_flag  = 1'b1;
			end else if (woke && rx_rise) begin
				next_wue  = 1'b0;
				next_woke = 1'b0;
			end
		end else if (run) begin
			if (!(serial_port_enable && continuous_receive_enable) || auto_rate_enable) begin
				// auto-rate enable only parks the receiver; no rate is measured, with or without wake
				next_rx_state = R_IDLE;
			end else if (rx_state == R_IDLE) begin
				if (!rx_sync) begin
					next_rx_state = R_START;
					next_rx_cnt   = 6'h00;
				end
			end else if (tick) begin
				next_rx_cnt = rx_cnt + 6'h01;
				unique case (rx_state)
					R_START: if (rx_cnt == half_last(high_speed_baud_select, wide_baud_divisor_select)) begin
						next_rx_cnt   = 6'h00;
						next_rx_bits  = 4'h0;
						next_rx_state = rx_sync ? R_IDLE : R_DATA;
					end
					R_DATA: if (rx_cnt == rx_bl) begin
						next_rx_cnt   = 6'h00;
						next_rx_shift = {rx_sync, rx_shift[8:1]};
						next_rx_bits  = rx_bits + 4'h1;
						if (rx_bits == (rx9 ? DATA9_LAST : DATA8_LAST)) begin
							next_rx_state = R_STOP;
						end
					end
					R_STOP: if (rx_cnt == rx_bl) begin
						next_rx_state = R_IDLE;
						word_done     = 1'b1;
					end
					default: next_rx_state = R_IDLE;
				endcase
			end
		end
		if (word_done && !(address_detect_enable && rx9 && !word_bit9)) begin
			if (rx_flag && !buf_read) begin
				next_overrun_error = 1'b1;
			end else begin
				next_rx_buf = word_data;
				next_received_ninth_bit   = word_bit9;
				next_framing_error   = ~rx_sync;
				set_flag    = 1'b1;
			end
		end
		if (!continuous_receive_enable) begin
			next_overrun_error = 1'b0;
			next_framing_error = 1'b0;
		end
		next_rx_flag = set_flag | (rx_flag & ~buf_read);
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			{serial_port_enable, rx9, single_receive_enable, continuous_receive_enable, address_detect_enable} <= 5'h00;
			{tx9, transmit_enable, high_speed_baud_select, tx9d}        <= 4'h0;
			{wide_baud_divisor_select, wake_on_edge_enable, auto_rate_enable, woke}      <= 4'h0;
			div_hi      <= DIV_RST;
			div_lo      <= DIV_RST;
			rx_state    <= R_IDLE;
			rx_cnt      <= 6'h00;
			rx_bits     <= 4'h0;
			rx_shift    <= 9'h000;
			rx_buf      <= 8'h00;
			{received_ninth_bit, framing_error, overrun_error, rx_flag} <= 4'h0;
			prdata_out  <= 32'h00000000;
			pslverr_out <= 1'b0;
		end else if (ce_in) begin
			{serial_port_enable, rx9, single_receive_enable, continuous_receive_enable, address_detect_enable} <= {next_serial_port_enable, next_rx9, next_single_receive_enable, next_continuous_receive_enable, next_address_detect_enable};
			{tx9, transmit_enable, high_speed_baud_select, tx9d}        <= {next_tx9, next_transmit_enable, next_high_speed_baud_select, next_tx9d};
			{wide_baud_divisor_select, wake_on_edge_enable, auto_rate_enable, woke}      <= {next_wide_baud_divisor_select, next_wue, next_auto_rate_enable, next_woke};
			div_hi      <= next_div_hi;
			div_lo      <= next_div_lo;
			rx_state    <= next_rx_state;
			rx_cnt      <= next_rx_cnt;
			rx_bits     <= next_rx_bits;
			rx_shift    <= next_rx_shift;
			rx_buf      <= next_rx_buf;
			{received_ninth_bit, framing_error, overrun_error, rx_flag} <= {next_received_ninth_bit, next_framing_error, next_overrun_error, next_rx_flag};
			prdata_out  <= next_prdata;
			pslverr_out <= next_pslverr;
		end
	end

	// ==========================================================
	// transmitter
	always_comb begin
		next_tx_state = tx_state;
		next_tx_cnt   = tx_cnt;
		next_tx_bits  = tx_bits;
		next_tx_shift = tx_shift;
		next_tx_hold  = tx_hold;
		next_tx_full  = tx_full;
		next_break_send_request    = break_send_request;
		next_tx_brk   = tx_brk;
		next_tx_line  = tx_line;
		if (wr_acc && paddr_in == OFF_TX_STAT) begin
			next_break_send_request = pwdata_in[B_BREAK_SEND_REQUEST];
		end
		if (run) begin
			if (!transmit_enable) begin
				next_tx_state = T_IDLE;
				next_tx_line  = 1'b1;
			end else if (tx_state == T_IDLE) begin
				if (tx_full) begin
					next_tx_state = T_START;
					next_tx_cnt   = 6'h00;
					next_tx_full  = 1'b0;
					next_tx_brk   = break_send_request;
					next_tx_shift = break_send_request ? 9'h000 : {tx9d, tx_hold};
					next_tx_line  = 1'b0;
				end
			end else if (tick) begin
				next_tx_cnt = tx_cnt + 6'h01;
				if (tx_cnt == tx_bl) begin
					next_tx_cnt = 6'h00;
					unique case (tx_state)
						T_START: begin
							next_tx_state = T_DATA;
							next_tx_bits  = 4'h0;
							next_tx_line  = tx_shift[0];
						end
						T_DATA: begin
							next_tx_shift = {1'b0, tx_shift[8:1]};
							next_tx_bits  = tx_bits + 4'h1;
							next_tx_line  = tx_shift[1];
							if (tx_bits == (tx_brk ? BREAK_LAST : tx9 ? DATA9_LAST : DATA8_LAST)) begin
								next_tx_state = T_STOP;
								next_tx_line  = 1'b1;
							end
						end
						T_STOP: begin
							next_tx_state = T_IDLE;
							if (tx_brk) begin
								next_break_send_request = 1'b0;
							end
						end
						default: next_tx_state = T_IDLE;
					endcase
				end
			end
		end
		if (wr_acc && paddr_in == OFF_TX_BUF) begin
			next_tx_hold = pwdata_in[7:0];
			next_tx_full = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			tx_state <= T_IDLE;
			tx_cnt   <= 6'h00;
			tx_bits  <= 4'h0;
			tx_shift <= 9'h000;
			tx_hold  <= 8'h00;
			tx_full  <= 1'b0;
			break_send_request    <= 1'b0;
			tx_brk   <= 1'b0;
			tx_line  <= 1'b1;
		end else if (ce_in) begin
			tx_state <= next_tx_state;
			tx_cnt   <= next_tx_cnt;
			tx_bits  <= next_tx_bits;
			tx_shift <= next_tx_shift;
			tx_hold  <= next_tx_hold;
			tx_full  <= next_tx_full;
			break_send_request    <= next_break_send_request;
			tx_brk   <= next_tx_brk;
			tx_line  <= next_tx_line;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);

	a_addr_discard: assert property (ce_in && word_done && address_detect_enable && rx9 && !word_bit9 && !rx_flag
		|=> !rx_flag) else $error("non-address word raised flag");
	a_ninth_bit: assert property (ce_in && word_done && !rx_flag && !(address_detect_enable && !word_bit9)
		|=> rx_flag && received_ninth_bit == $past(word_bit9)) else $error("ninth bit lost");
	a_error_clear: assert property (ce_in && !continuous_receive_enable |=> !overrun_error && !framing_error)
		else $error("errors survive receive disable");
	a_sleep_freeze: assert property (sleep_in && !wake_on_edge_enable |=> $stable(rx_state) && $stable(tx_state))
		else $error("state moved in sleep");
	a_wake_idle: assert property (ce_in && wake_on_edge_enable |=> rx_state == R_IDLE)
		else $error("receiver active under wake");
	a_wake_flag: assert property (ce_in && wake_on_edge_enable && !woke && rx_fall |=> rx_flag && woke)
		else $error("wake edge not flagged");
	a_read_clear: assert property (ce_in && buf_read && !set_flag |=> !rx_flag)
		else $error("flag not cleared by read");
	a_wake_end: assert property (ce_in && wake_on_edge_enable && woke && rx_rise |=> !wake_on_edge_enable)
		else $error("wake enable not cleared");
	a_break_zero: assert property (tx_brk && tx_state == T_DATA |-> !tx_line)
		else $error("break bit not zero");
	a_break_clear: assert property (ce_in && run && tick && transmit_enable && tx_state == T_STOP && tx_brk
		&& tx_cnt == tx_bl |=> !break_send_request && shifter_empty_status) else $error("break request kept");
endmodule // uart_addr_wake_break

/* File: inc/uart_wake_pkg.sv */
package uart_wake_pkg;
	// ==========================================================
	// register byte offsets on the APB word grid
	localparam logic [7:0] OFF_RX_STAT = 8'h00;
	localparam logic [7:0] OFF_RX_BUF  = 8'h04;
	localparam logic [7:0] OFF_TX_STAT = 8'h08;
	localparam logic [7:0] OFF_BAUD    = 8'h0C;
	localparam logic [7:0] OFF_DIV_HI  = 8'h10;
	localparam logic [7:0] OFF_DIV_LO  = 8'h14;
	localparam logic [7:0] OFF_TX_BUF  = 8'h18;

	// ==========================================================
	// receive_status_control fields
	localparam int B_SERIAL_PORT_ENABLE  = 7;
	localparam int B_RX9   = 6;
	localparam int B_SINGLE_RECEIVE_ENABLE  = 5;
	localparam int B_CONTINUOUS_RECEIVE_ENABLE  = 4;
	localparam int B_ADDRESS_DETECT_ENABLE = 3;
	// transmit_status_control fields
	localparam int B_TX9   = 6;
	localparam int B_TRANSMIT_ENABLE  = 5;
	localparam int B_BREAK_SEND_REQUEST = 3;
	localparam int B_HIGH_SPEED_BAUD_SELECT  = 2;
	localparam int B_TX9D  = 0;
	// baud_control fields
	localparam int B_WIDE_BAUD_DIVISOR_SELECT = 3;
	localparam int B_WUE   = 1;
	localparam int B_AUTO_RATE_ENABLE = 0;

	// ==========================================================
	// reset values
	localparam logic [7:0] DIV_RST = 8'h00;

	// ==========================================================
	// timing: last tick index of a bit and of half a bit; last bit index of a word and of a break
	localparam logic [5:0] BIT_LAST_SLOW  = 6'h3F;
	localparam logic [5:0] BIT_LAST_MID   = 6'h0F;
	localparam logic [5:0] BIT_LAST_FAST  = 6'h03;
	localparam logic [5:0] HALF_LAST_SLOW = 6'h1F;
	localparam logic [5:0] HALF_LAST_MID  = 6'h07;
	localparam logic [5:0] HALF_LAST_FAST = 6'h01;
	localparam logic [3:0] DATA8_LAST     = 4'h7;
	localparam logic [3:0] DATA9_LAST     = 4'h8;
	localparam logic [3:0] BREAK_LAST     = 4'hB;

	typedef enum logic [1:0] {
		R_IDLE  = 2'b00,
		R_START = 2'b01,
		R_DATA  = 2'b11,
		R_STOP  = 2'b10
	} rx_state_t;

	typedef enum logic [1:0] {
		T_IDLE  = 2'b00,
		T_START = 2'b01,
		T_DATA  = 2'b11,
		T_STOP  = 2'b10
	} tx_state_t;
endpackage

/* File: inc/baud_if.sv */
`timescale 1ns/100ps
interface baud_if;
	logic [15:0] divisor;
	logic        wide;
	logic        run;
	logic        tick;
	modport gen  (input divisor, input wide, input run, output tick);
	modport user (output divisor, output wide, output run, input tick);
endinterface // baud_if

/* File: hdl/baud_gen.sv */
`timescale 1ns/100ps
module baud_gen (
	input  wire logic ref_clk_in,
	input  wire logic sys_rst_in,
	input  wire logic ce_in,
	baud_if.gen       bif
);
	logic [15:0] cnt;
	logic [15:0] next_cnt;
	logic        tick;
	logic        next_tick;
	logic [15:0] limit;

	// ==========================================================
	// tick once every divisor+1 clocks; only the low divisor byte counts unless wide
	always_comb begin
		limit     = bif.wide ? bif.divisor : {8'h00, bif.divisor[7:0]};
		next_cnt  = cnt + 16'h0001;
		next_tick = 1'b0;
		if (!bif.run) begin
			next_cnt = 16'h0000;
		end else if (cnt >= limit) begin
			next_cnt  = 16'h0000;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			cnt  <= 16'h0000;
			tick <= 1'b0;
		end else if (ce_in) begin
			cnt  <= next_cnt;
			tick <= next_tick;
		end
	end

	assign bif.tick = tick & ce_in;
endmodule // baud_gen

/* File: dv/remote_node.sv */
`timescale 1ns/100ps
module remote_node #(
	parameter int BIT_CLK = 8
) (
	input  wire logic ref_clk_in,
	input  wire logic tx_line_in,
	output logic      rx_line_out
);
	logic [12:0] frames[$];
	logic [12:0] cap;

	// ==========================================================
	// sender: the line idles high, as the pull-up leaves it
	initial rx_line_out = 1'b1;

	// start bit, then lsb first, one stop bit, one idle bit
	task automatic send(input logic [8:0] word, input int nbits, input logic stop_bit);
		rx_line_out <= 1'b0;
		repeat (BIT_CLK) @(posedge ref_clk_in);
		for (int i = 0; i < nbits; i++) begin
			rx_line_out <= word[i];
			repeat (BIT_CLK) @(posedge ref_clk_in);
		end
		rx_line_out <= stop_bit;
		repeat (BIT_CLK) @(posedge ref_clk_in);
		rx_line_out <= 1'b1;
		repeat (BIT_CLK) @(posedge ref_clk_in);
	endtask

	// a held level; a low run is an all-zero break character
	task automatic drive(input logic level, input int nbits);
		rx_line_out <= level;
		repeat (nbits * BIT_CLK) @(posedge ref_clk_in);
	endtask

	// ==========================================================
	// listener: 13 mid-bit samples after each start bit
	// long enough to hold a whole break including its stop bit
	initial begin
		forever begin
			@(posedge ref_clk_in);
			if (tx_line_in === 1'b0) begin
				repeat (BIT_CLK / 2 - 1) @(posedge ref_clk_in);
				for (int i = 0; i < 13; i++) begin
					repeat (BIT_CLK) @(posedge ref_clk_in);
					cap[i] = tx_line_in;
				end
				frames.push_back(cap);
			end
		end
	end
endmodule // remote_node

/* File: dv/tb_uart_addr_wake_break.sv */
`timescale 1ns/100ps
module tb_uart_addr_wake_break import uart_wake_pkg::*; ;
	typedef struct packed {
		logic [7:0] cfg;
		logic [8:0] word;
		logic       flag;
		logic [7:0] stat;
	} row_t;

	logic        ref_clk_in;
	logic        sys_rst_in;
	logic        ce_in;
	logic        sleep_in;
	logic [7:0]  paddr_in;
	logic        psel_in;
	logic        penable_in;
	logic        pwrite_in;
	logic [31:0] pwdata_in;
	logic [31:0] prdata_out;
	logic        pready_out;
	logic        pslverr_out;
	logic        rx_line;
	logic        tx_line;
	logic        rx_flag;
	logic        tx_empty;
	logic        wake_async;
	logic [31:0] rd;
	logic        serr;
	int          err_total;
	int          checked;
	row_t        rows[7] = '{
		'{8'h90, 9'h0A5, 1'b1, 8'h90},
		'{8'h90, 9'h0FF, 1'b1, 8'h90},
		'{8'hD0, 9'h13C, 1'b1, 8'hD1},
		'{8'hD0, 9'h0C3, 1'b1, 8'hD0},
		'{8'hD8, 9'h05A, 1'b0, 8'hD8},
		'{8'hD8, 9'h1A7, 1'b1, 8'hD9},
		'{8'hD0, 9'h042, 1'b1, 8'hD0}
	};

	uart_addr_wake_break uart_addr_wake_break_i (
		.ref_clk_in                     (ref_clk_in),
		.sys_rst_in                     (sys_rst_in),
		.ce_in                          (ce_in),
		.sleep_in                       (sleep_in),
		.paddr_in                       (paddr_in),
		.psel_in                        (psel_in),
		.penable_in                     (penable_in),
		.pwrite_in                      (pwrite_in),
		.pwdata_in                      (pwdata_in),
		.prdata_out                     (prdata_out),
		.pready_out                     (pready_out),
		.pslverr_out                    (pslverr_out),
		.rx_line_in                     (rx_line),
		.tx_line_out                    (tx_line),
		.receive_flag_out               (rx_flag),
		.transmit_buffer_empty_flag_out (tx_empty),
		.wake_async_out                 (wake_async)
	);

	remote_node remote_node_i (
		.ref_clk_in  (ref_clk_in),
		.tx_line_in  (tx_line),
		.rx_line_out (rx_line)
	);

	// ==========================================================
	// helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		if (err_total == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// one idle cycle first, so back-to-back calls never drive psel twice at one edge
	task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
		int n;
		@(posedge ref_clk_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		paddr_in <= a;
		pwrite_in <= w;
		pwdata_in <= {24'h000000, d};
		@(posedge ref_clk_in);
		penable_in <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 50);
		if (n >= 50) err_total++;
		rd = prdata_out;
		serr = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(a, 1'b1, d);
	endtask

	task automatic rdck(input logic [7:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 8'h00);
		check(rd, exp);
	endtask

	task automatic wait_flag(input int lim);
		for (int i = 0; i < lim && rx_flag !== 1'b1; i++) @(posedge ref_clk_in);
	endtask

	initial begin
		ref_clk_in = 1'b0;
		forever #25 ref_clk_in = ~ref_clk_in;
	end

	initial begin
		repeat (30000) @(posedge ref_clk_in);
		err_total++;
		finish_test();
	end

	// ==========================================================
	// main sequence
	initial begin
		err_total = 0;
		checked = 0;
		sys_rst_in = 1'b1;
		sleep_in = 1'b0;
		ce_in = 1'b1;
		paddr_in = 8'h00;
		psel_in = 1'b0;
		penable_in = 1'b0;
		pwrite_in = 1'b0;
		pwdata_in = 32'h00000000;
		repeat (20) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		// fastest bit: 4 ticks of 2 clocks, 8 clocks a bit
		wr(OFF_DIV_HI, 8'h00);
		wr(OFF_DIV_LO, 8'h01);
		wr(OFF_BAUD, 8'h08);
		wr(OFF_TX_STAT, 8'h24);
		rdck(OFF_DIV_LO, 32'h00000001);
		foreach (rows[k]) begin
			wr(OFF_RX_STAT, rows[k].cfg);
			remote_node_i.send(rows[k].word, rows[k].cfg[B_RX9] ? 9 : 8, 1'b1);
			wait_flag(30);
			check(32'(rx_flag), 32'(rows[k].flag));
			rdck(OFF_RX_STAT, {24'h000000, rows[k].stat});
			if (rows[k].flag) begin
				rdck(OFF_RX_BUF, {24'h000000, rows[k].word[7:0]});
				@(posedge ref_clk_in);
				check(32'(rx_flag), 32'h00000000);
			end
		end
		// framing error, then overrun, then clearing by the enable
		wr(OFF_RX_STAT, 8'h90);
		remote_node_i.send(9'h011, 8, 1'b0);
		wait_flag(30);
		rdck(OFF_RX_STAT, 32'h00000094);
		remote_node_i.send(9'h022, 8, 1'b1);
		apb(OFF_RX_STAT, 1'b0, 8'h00);
		check(rd & 32'h00000002, 32'h00000002);
		wr(OFF_RX_STAT, 8'h80);
		rdck(OFF_RX_STAT, 32'h00000080);
		apb(OFF_RX_BUF, 1'b0, 8'h00);
		// wake on a break while awake
		wr(OFF_RX_STAT, 8'h90);
		wr(OFF_BAUD, 8'h0A);
		remote_node_i.drive(1'b0, 13);
		check(32'(rx_flag), 32'h00000001);
		check(32'(wake_async), 32'h00000000);
		apb(OFF_BAUD, 1'b0, 8'h00);
		check(32'(rd[B_WUE]), 32'h00000001);
		remote_node_i.drive(1'b1, 1);
		apb(OFF_BAUD, 1'b0, 8'h00);
		check(32'(rd[B_WUE]), 32'h00000000);
		rdck(OFF_RX_STAT, 32'h00000090);
		apb(OFF_RX_BUF, 1'b0, 8'h00);
		@(posedge ref_clk_in);
		check(32'(rx_flag), 32'h00000000);
		remote_node_i.send(9'h03C, 8, 1'b1);
		wait_flag(30);
		rdck(OFF_RX_BUF, 32'h0000003C);
		// slowed receiver: break stop edge lands before the stop sample
		wr(OFF_DIV_LO, 8'h02);
		remote_node_i.drive(1'b0, 13);
		remote_node_i.drive(1'b1, 2);
		wait_flag(30);
		rdck(OFF_RX_STAT, 32'h00000090);
		rdck(OFF_RX_BUF, 32'h00000000);
		wr(OFF_DIV_LO, 8'h01);
		// auto-rate parks the receiver: a frame raises nothing
		wr(OFF_BAUD, 8'h09);
		remote_node_i.send(9'h0C3, 8, 1'b1);
		check(32'(rx_flag), 32'h00000000);
		rdck(OFF_BAUD, 32'h00000049);
		// wake while asleep, then a frame lost in sleep
		wr(OFF_BAUD, 8'h0A);
		sleep_in <= 1'b1;
		remote_node_i.drive(1'b0, 0);
		// the raw-pin wake only stands until the core catches the edge
		@(posedge ref_clk_in);
		check(32'(wake_async), 32'h00000001);
		remote_node_i.drive(1'b0, 2);
		check(32'(rx_flag), 32'h00000001);
		sleep_in <= 1'b0;
		remote_node_i.drive(1'b1, 1);
		apb(OFF_RX_BUF, 1'b0, 8'h00);
		sleep_in <= 1'b1;
		remote_node_i.send(9'h05A, 8, 1'b1);
		repeat (20) @(posedge ref_clk_in);
		check(32'(rx_flag), 32'h00000000);
		sleep_in <= 1'b0;
		apb(OFF_RX_BUF, 1'b0, 8'h00);
		// break then sync byte; dummy data must not leak out
		remote_node_i.frames.delete();
		wr(OFF_TX_STAT, 8'h2C);
		wr(OFF_TX_BUF, 8'hFF);
		// let the buffer-full update settle before polling the empty flag
		@(posedge ref_clk_in);
		for (int i = 0; i < 50 && tx_empty !== 1'b1; i++) @(posedge ref_clk_in);
		check(32'(tx_empty), 32'h00000001);
		wr(OFF_TX_BUF, 8'h55);
		apb(OFF_TX_STAT, 1'b0, 8'h00);
		check(rd & 32'h0000000A, 32'h00000008);
		check(32'(tx_empty), 32'h00000000);
		for (int i = 0; i < 600 && remote_node_i.frames.size() < 2; i++) @(posedge ref_clk_in);
		check(32'(remote_node_i.frames[0]), 32'h00001000);
		check(32'(remote_node_i.frames[1]), 32'h00001F55);
		rdck(OFF_TX_STAT, 32'h00000026);
		// clock enable low stalls the access until it returns
		ce_in <= 1'b0;
		fork
			wr(OFF_DIV_HI, 8'h3C);
			begin
				repeat (4) @(posedge ref_clk_in);
				check(32'(pready_out), 32'h00000000);
				ce_in <= 1'b1;
			end
		join
		rdck(OFF_DIV_HI, 32'h0000003C);
		// second reset in mid-run, then an unmapped word
		sys_rst_in <= 1'b1;
		repeat (20) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		rdck(OFF_RX_STAT, 32'h00000000);
		rdck(OFF_TX_STAT, 32'h00000002);
		rdck(OFF_BAUD, 32'h00000040);
		rdck(OFF_DIV_LO, 32'h00000000);
		apb(8'h1C, 1'b0, 8'h00);
		check(rd, 32'h00000000);
		check(32'(serr), 32'h00000001);
		finish_test();
	end
endmodule // tb_uart_addr_wake_break
